//--- crg_defs.svh
`ifndef CRG_DEFS_SVH
`define CRG_DEFS_SVH
// Clock rate and the derived line clock rates.
`define CRG_CLK_HZ 10000000
`define CRG_FRAME_HZ 8000
`define CRG_DATA_CLK_HZ 1536000
`define CRG_BIT_CLK_HZ 768000
`define CRG_BITS_PER_FRAME (`CRG_BIT_CLK_HZ / `CRG_FRAME_HZ)
// Reset pulse lengths in frames of the frame sync clock, watchdog period, undervoltage hold time, PLL run length.
`define CRG_WAKE_PULSE_FRAMES 2'h2
`define CRG_WD_PULSE_FRAMES 2'h1
`define CRG_WD_PERIOD_MS 128
`define CRG_WD_FRAMES (`CRG_WD_PERIOD_MS * `CRG_FRAME_HZ / 1000)
`define CRG_DEACT_MS 64
`define CRG_DEACT_CYCLES (`CRG_DEACT_MS * (`CRG_CLK_HZ / 1000))
`define CRG_PLL_RUN 3'h6
// Register byte offsets.
`define CRG_OFS_CFG 5'h00
`define CRG_OFS_TRCFG 5'h04
`define CRG_OFS_ISR 5'h08
`define CRG_OFS_SOFTRST 5'h0c
`define CRG_OFS_WDT 5'h10
`define CRG_OFS_STAT 5'h14
// Field positions and reset values.
`define CRG_CFG_MCLK 1:0
`define CRG_CFG_DOUBLE 2
`define CRG_CFG_RSS 4:3
`define CRG_CFG_RST 5'h00
`define CRG_TRCFG_INTD 0
`define CRG_ISR_OVF 0
`define CRG_WDT_A 0
`define CRG_WDT_B 1
// Microcontroller clock half periods in clock cycles, before doubling.
`define CRG_MCLK_HALF_DIV1 5'h02
`define CRG_MCLK_HALF_DIV2 5'h04
`define CRG_MCLK_HALF_DIV8 5'h10
`endif

//--- crg_pkg.sv
`default_nettype none
package crg_pkg;
  // Reset source choices on the shared reset or strobe pin.
  typedef enum logic [1:0] {
    CRG_RSS_NONE = 2'h0,
    CRG_RSS_STROBE = 2'h1,
    CRG_RSS_WAKE = 2'h2,
    CRG_RSS_WATCHDOG = 2'h3
  } crg_rss_e;
  // Watchdog servicing sequence tracker.
  typedef enum logic {
    CRG_WD_EXPECT_A = 1'b0,
    CRG_WD_EXPECT_B = 1'b1
  } crg_wdseq_e;
endpackage
`default_nettype wire

//--- crg_clock_reset.sv
// Function
// - All clocks derive from the oscillator clock.
// - PLL makes frame, data, bit clocks.
// - Prescaler divides 1, 2, 8; 11 disables.
// - Double select doubles microcontroller clock rate.
// - Integrator: adjust after six same deviations.
// - Each correction shifts data clock one oscillator clock period.
// - Transmit clock derived from recovered receive clock.
// - Hardware, undervoltage and per-block soft resets.
// - Hardware reset always drives reset output.
// - Reset pulse lengths timed by frame sync.
// - Select: none, strobe, wake sources, watchdog.
// - Strobe mode: only hardware/undervoltage resets shown.
// - Command code change gives 125-250 us pulse.
// - Wake low restarts oscillator, gives pulse.
// - Selecting watchdog clears and starts timer.
// - Expiry sets overflow flag, 125 us pulse.
// - Watchdog selection locks select field.
// - Undervoltage enable is a sampled strap.
// - Hold reset 64 ms after undervoltage clears.
// - Undervoltage resets registers, stops clock at once.
// - After release clock resumes default rate.
// - Hardware reset released on falling bit clock when the strap is off; with the strap, after the 64 ms hold.
// - Soft reset bit holds block while set.
`timescale 1ns/1ps
`default_nettype none
`include "crg_defs.svh"

module crg_clock_reset #(
  parameter int unsigned DEACT_CYCLES = `CRG_DEACT_CYCLES,
  parameter int unsigned WD_FRAMES = `CRG_WD_FRAMES,
  parameter int unsigned NUM_BLOCKS = 4
) (
  // Clock and hardware reset.
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM register slave.
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Line side and external inputs.
  input wire logic line_pulse,
  input wire logic [3:0] command_indicate_down,
  input wire logic subscriber_wake_in,
  input wire logic undervoltage_enable_strap,
  input wire logic undervoltage_det,
  input wire logic second_strobe_function,
  // Generated clocks.
  output logic frame_sync_clock,
  output logic double_rate_data_clock,
  output logic serial_bit_clock,
  output logic line_tx_clock,
  output logic mclk_out,
  // Resets and wake.
  output logic reset_or_strobe_out,
  output logic [NUM_BLOCKS-1:0] block_reset,
  output logic oscillator_wake
);

  localparam logic [23:0] DATA_STEP = 24'(2 * `CRG_DATA_CLK_HZ);
  localparam logic [23:0] PHASE_MOD = 24'(`CRG_CLK_HZ);
  localparam logic [6:0] BIT_LAST = 7'(`CRG_BITS_PER_FRAME - 1);
  localparam logic [19:0] DEACT_LAST = 20'(DEACT_CYCLES - 1);
  localparam logic [10:0] WD_LAST = 11'(WD_FRAMES - 1);

  logic strap_q;
  logic uv_active;
  logic regs_rst;
  logic sys_hold_q;
  logic [19:0] deact_q;
  logic [23:0] nco_q;
  logic data_clk_q, bit_clk_q, frame_q;
  logic data_rise, bit_fall, frame_tick;
  logic [6:0] bit_cnt_q;
  logic adj_len, adj_short;
  logic dir_q;
  logic [2:0] run_q;
  logic [4:0] cfg_q;
  logic intd_q;
  logic wov_q;
  logic [NUM_BLOCKS-1:0] block_soft_reset_reg_q;
  logic ack_q;
  logic bus_wr, bus_rd;
  crg_pkg::crg_rss_e rss;
  crg_pkg::crg_wdseq_e seq_q;
  logic wdt_wr, wd_restart, wd_expire, wd_select;
  logic [10:0] wd_cnt_q;
  logic [3:0] ci_prev_q;
  logic wake_prev_q;
  logic ci_event, wake_event;
  logic [1:0] pulse_q;
  logic [4:0] mclk_cnt_q, mclk_half;
  logic mclk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset management.

  // The strap is caught while the hardware reset is held, never by the reset itself.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_q <= undervoltage_enable_strap;
    end
  end

  assign uv_active = strap_q && undervoltage_det;
  // Registers reset from the hardware pin or undervoltage at once.
  assign regs_rst = !reset_n || uv_active;

  // Output-side reset hold: bit clock release without the strap, 64 ms with it.
  always_ff @(posedge clk) begin
    if (!reset_n || uv_active) begin
      sys_hold_q <= 1'b1;
      deact_q <= 20'h00000;
    end else if (sys_hold_q) begin
      if (strap_q) begin
        deact_q <= deact_q + 20'h00001;
        if (deact_q == DEACT_LAST) begin
          sys_hold_q <= 1'b0;
        end
      end else if (bit_fall) begin
        sys_hold_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital phase lock: fractional divider from the oscillator clock.

  // A correction skips one accumulate (longer) or adds twice (shorter).
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nco_q <= 24'h000000;
      data_clk_q <= 1'b0;
    end else begin
      if (adj_len) begin
        nco_q <= nco_q;
      end else if (nco_q + (adj_short ? 24'(2 * DATA_STEP) : DATA_STEP) >= PHASE_MOD) begin
        nco_q <= nco_q + (adj_short ? 24'(2 * DATA_STEP) : DATA_STEP) - PHASE_MOD;
        data_clk_q <= !data_clk_q;
      end else begin
        nco_q <= nco_q + (adj_short ? 24'(2 * DATA_STEP) : DATA_STEP);
      end
    end
  end

  assign data_rise = !data_clk_q && !adj_len &&
                     (nco_q + (adj_short ? 24'(2 * DATA_STEP) : DATA_STEP) >= PHASE_MOD);

  // Bit clock halves the data clock; frame sync marks every 96th bit.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bit_clk_q <= 1'b0;
      bit_cnt_q <= 7'h00;
      frame_q <= 1'b0;
    end else if (data_rise) begin
      bit_clk_q <= !bit_clk_q;
      if (bit_clk_q) begin
        bit_cnt_q <= (bit_cnt_q == BIT_LAST) ? 7'h00 : bit_cnt_q + 7'h01;
        frame_q <= (bit_cnt_q == BIT_LAST);
      end
    end
  end

  assign bit_fall = data_rise && bit_clk_q;
  assign frame_tick = bit_fall && (bit_cnt_q == BIT_LAST);

  // Deviation filter: integrator waits for six alike, otherwise every pulse.
  always_ff @(posedge clk) begin
    if (regs_rst) begin
      dir_q <= 1'b0;
      run_q <= 3'h0;
    end else if (line_pulse) begin
      dir_q <= data_clk_q;
      if (intd_q || adj_len || adj_short) begin
        run_q <= 3'h0;
      end else if (dir_q == data_clk_q) begin
        run_q <= run_q + 3'h1;
      end else begin
        run_q <= 3'h1;
      end
    end
  end

  // A pulse during the high half means the local clock is early: lengthen.
  assign adj_len = line_pulse && data_clk_q &&
                   (intd_q || (dir_q && run_q == `CRG_PLL_RUN - 3'h1));
  assign adj_short = line_pulse && !data_clk_q &&
                     (intd_q || (!dir_q && run_q == `CRG_PLL_RUN - 3'h1));

  assign frame_sync_clock = frame_q;
  assign double_rate_data_clock = data_clk_q;
  assign serial_bit_clock = bit_clk_q;
  // Transmit follows the recovered receive timing, so no own generator.
  assign line_tx_clock = bit_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Microcontroller clock prescaler.

  always_comb begin
    case (cfg_q[`CRG_CFG_MCLK])
      2'h0: mclk_half = `CRG_MCLK_HALF_DIV1;
      2'h1: mclk_half = `CRG_MCLK_HALF_DIV2;
      2'h2: mclk_half = `CRG_MCLK_HALF_DIV8;
      default: mclk_half = 5'h00;
    endcase
    if (cfg_q[`CRG_CFG_DOUBLE]) begin
      mclk_half = mclk_half >> 1;
    end
  end

  // Reset puts the select back to its default, so release resumes that rate.
  always_ff @(posedge clk) begin
    if (regs_rst || mclk_half == 5'h00) begin
      mclk_cnt_q <= 5'h00;
      mclk_q <= 1'b0;
    end else if (mclk_cnt_q >= mclk_half - 5'h01) begin
      mclk_cnt_q <= 5'h00;
      mclk_q <= !mclk_q;
    end else begin
      mclk_cnt_q <= mclk_cnt_q + 5'h01;
    end
  end

  // Gated so undervoltage stops the clock the moment it is seen.
  assign mclk_out = mclk_q && !uv_active;

  ////////////////////////////////////////////////////////////////////////////
  // Register slave: one wait cycle, then the access completes.

  assign waitrequest = (read || write) && !ack_q;
  assign bus_wr = write && ack_q;
  assign bus_rd = read && ack_q;
  assign wdt_wr = bus_wr && address == `CRG_OFS_WDT;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_q) begin
      case (address)
        `CRG_OFS_CFG: readdata <= {27'h0000000, cfg_q};
        `CRG_OFS_TRCFG: readdata <= {31'h00000000, intd_q};
        `CRG_OFS_ISR: readdata <= {31'h00000000, wov_q};
        `CRG_OFS_SOFTRST: readdata <= 32'(block_soft_reset_reg_q);
        `CRG_OFS_STAT: readdata <= {24'h000000, 1'b0, run_q, strap_q, seq_q,
                                    (pulse_q != 2'h0), sys_hold_q};
        default: readdata <= 32'h00000000;
      endcase
    end
  end

  assign rss = crg_pkg::crg_rss_e'(cfg_q[`CRG_CFG_RSS]);
  assign wd_select = bus_wr && address == `CRG_OFS_CFG &&
                     rss != crg_pkg::CRG_RSS_WATCHDOG &&
                     writedata[4:3] == 2'(crg_pkg::CRG_RSS_WATCHDOG);

  // Configuration; once the watchdog is chosen only a reset frees the select.
  always_ff @(posedge clk) begin
    if (regs_rst) begin
      cfg_q <= `CRG_CFG_RST;
      intd_q <= 1'b0;
    end else begin
      if (bus_wr && address == `CRG_OFS_CFG) begin
        cfg_q[2:0] <= writedata[2:0];
        if (rss != crg_pkg::CRG_RSS_WATCHDOG) begin
          cfg_q[`CRG_CFG_RSS] <= writedata[4:3];
        end
      end
      if (bus_wr && address == `CRG_OFS_TRCFG) begin
        intd_q <= writedata[`CRG_TRCFG_INTD];
      end
    end
  end

  // Soft reset bits hold their block for as long as they read one.
  always_ff @(posedge clk) begin
    if (regs_rst) begin
      block_soft_reset_reg_q <= '0;
    end else if (bus_wr && address == `CRG_OFS_SOFTRST) begin
      block_soft_reset_reg_q <= writedata[NUM_BLOCKS-1:0];
    end
  end

  generate
    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
      assign block_reset[i] = block_soft_reset_reg_q[i] || regs_rst;
    end
  endgenerate

  // Overflow flag: write one to clear, but a new expiry in that cycle wins.
  always_ff @(posedge clk) begin
    if (regs_rst) begin
      wov_q <= 1'b0;
    end else if (wd_expire) begin
      wov_q <= 1'b1;
    end else if (bus_wr && address == `CRG_OFS_ISR && writedata[`CRG_ISR_OVF]) begin
      wov_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, counted in frames.

  // Step A arms the tracker, step B completes; anything else disarms.
  always_ff @(posedge clk) begin
    if (regs_rst || wd_select || wd_restart) begin
      seq_q <= crg_pkg::CRG_WD_EXPECT_A;
    end else if (wdt_wr) begin
      if (writedata[`CRG_WDT_A] && !writedata[`CRG_WDT_B]) begin
        seq_q <= crg_pkg::CRG_WD_EXPECT_B;
      end else begin
        seq_q <= crg_pkg::CRG_WD_EXPECT_A;
      end
    end
  end

  assign wd_restart = wdt_wr && seq_q == crg_pkg::CRG_WD_EXPECT_B &&
                      !writedata[`CRG_WDT_A] && writedata[`CRG_WDT_B];
  assign wd_expire = rss == crg_pkg::CRG_RSS_WATCHDOG && frame_tick && wd_cnt_q == WD_LAST;

  always_ff @(posedge clk) begin
    if (regs_rst || wd_select || wd_restart || wd_expire) begin
      wd_cnt_q <= 11'h000;
    end else if (rss == crg_pkg::CRG_RSS_WATCHDOG && frame_tick) begin
      wd_cnt_q <= wd_cnt_q + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake sources and the generated reset pulse.

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      ci_prev_q <= command_indicate_down;
      wake_prev_q <= 1'b1;
    end else begin
      ci_prev_q <= command_indicate_down;
      wake_prev_q <= subscriber_wake_in;
    end
  end

  assign ci_event = ci_prev_q != command_indicate_down;
  // A 65 ns pulse can fall between two samples, as the clock period is longer.
  assign wake_event = wake_prev_q && !subscriber_wake_in;
  assign oscillator_wake = !subscriber_wake_in;

  // Frames left in the pulse; starting mid-frame gives 125 to 250 us.
  always_ff @(posedge clk) begin
    if (regs_rst) begin
      pulse_q <= 2'h0;
    end else if (rss == crg_pkg::CRG_RSS_WAKE && (ci_event || wake_event)) begin
      pulse_q <= `CRG_WAKE_PULSE_FRAMES;
    end else if (wd_expire) begin
      pulse_q <= `CRG_WD_PULSE_FRAMES;
    end else if (frame_tick && pulse_q != 2'h0) begin
      pulse_q <= pulse_q - 2'h1;
    end
  end

  // The system hold shows in every mode; strobe mode shows nothing else.
  always_comb begin
    if (sys_hold_q) begin
      reset_or_strobe_out = 1'b0;
    end else if (rss == crg_pkg::CRG_RSS_STROBE) begin
      reset_or_strobe_out = second_strobe_function;
    end else begin
      reset_or_strobe_out = (pulse_q == 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_hold_drives_out: assert property (@(posedge clk) sys_hold_q |-> !reset_or_strobe_out)
    else $error("reset output not low during hold");
  a_uv_stops_mclk: assert property (@(posedge clk) uv_active |-> !mclk_out)
    else $error("mclk running during undervoltage");
  a_rss_locked: assert property (@(posedge clk) disable iff (regs_rst)
      rss == crg_pkg::CRG_RSS_WATCHDOG |=> rss == crg_pkg::CRG_RSS_WATCHDOG)
    else $error("watchdog selection changed");
  a_wd_pulse_len: assert property (@(posedge clk) disable iff (regs_rst)
      wd_expire |=> (pulse_q == 2'h1) && !reset_or_strobe_out)
    else $error("watchdog pulse not started");
  a_wd_flag_set: assert property (@(posedge clk) disable iff (regs_rst) wd_expire |=> wov_q)
    else $error("overflow flag not set");
  a_select_clears_wd: assert property (@(posedge clk) disable iff (regs_rst)
      wd_select |=> wd_cnt_q == 11'h000 && seq_q == crg_pkg::CRG_WD_EXPECT_A)
    else $error("watchdog not cleared on selection");
  a_bad_order_no: assert property (@(posedge clk) disable iff (regs_rst)
      wdt_wr && writedata[1:0] != 2'h1 |=> seq_q == crg_pkg::CRG_WD_EXPECT_A)
    else $error("tracker not back to first step");
  a_strobe_passes: assert property (@(posedge clk)
      !sys_hold_q && rss == crg_pkg::CRG_RSS_STROBE |-> reset_or_strobe_out == second_strobe_function)
    else $error("strobe not passed");
  a_mclk_off_sel: assert property (@(posedge clk) disable iff (regs_rst)
      cfg_q[1:0] == 2'h3 ##1 cfg_q[1:0] == 2'h3 |-> !mclk_out)
    else $error("mclk not disabled");
  a_hw_release_edge: assert property (@(posedge clk)
      $fell(sys_hold_q) && !strap_q |-> $past(bit_fall))
    else $error("release not on bit clock fall");
  a_block_soft_reset_reg_holds: assert property (@(posedge clk) disable iff (regs_rst)
      bus_wr && address == `CRG_OFS_SOFTRST && writedata[0] |=> block_reset[0])
    else $error("soft reset not held");

  c_wd_expire: cover property (@(posedge clk) wd_expire);
  c_wd_service: cover property (@(posedge clk) wd_restart);
  c_wake_pulse: cover property (@(posedge clk) rss == crg_pkg::CRG_RSS_WAKE && wake_event);
  c_pll_adjust: cover property (@(posedge clk) adj_len || adj_short);

endmodule // crg_clock_reset
`default_nettype wire

//--- crg_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module crg_line_model #(
  parameter int GAP = 1300
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control from the bench.
  input wire logic [3:0] code_in,
  input wire logic pulse_en,
  // Line side outputs.
  output logic line_pulse,
  output logic [3:0] command_indicate_down
);
  int cnt_q;

  // One receive pulse per GAP clocks; the gap is a little off the frame so the PLL must correct.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 0;
      line_pulse <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= GAP - 1) ? 0 : cnt_q + 1;
      line_pulse <= pulse_en && (cnt_q == GAP - 1);
    end
  end

  // The downstream code is a level; it keeps its value through reset, as a real line would.
  always_ff @(posedge clk) begin
    command_indicate_down <= code_in;
  end
endmodule // crg_line_model
`default_nettype wire

//--- crg_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "crg_defs.svh"

module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] code = 4'h0;
  logic pulse_en = 1'b0;
  logic wake_n = 1'b1;
  logic strap = 1'b0;
  logic uv = 1'b0;
  logic strobe = 1'b0;
  logic [31:0] readdata, rd;
  logic waitrequest, line_pulse, frm, dclk, bclk, txc, mclk, ros, owake;
  logic [3:0] cmd_down, blk;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int h, len, fr, nb, nd, bad, rises;
  logic pb, pd, pf;
  logic [31:0] mv[6] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h5, 32'h6};
  int mh[6] = '{2, 4, 16, 1, 2, 8};

  crg_line_model lm (.clk(clk), .reset_n(reset_n), .code_in(code), .pulse_en(pulse_en),
    .line_pulse(line_pulse), .command_indicate_down(cmd_down));

  crg_clock_reset #(.DEACT_CYCLES(50), .WD_FRAMES(4), .NUM_BLOCKS(4)) uut (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .line_pulse(line_pulse), .command_indicate_down(cmd_down),
    .subscriber_wake_in(wake_n), .undervoltage_enable_strap(strap),
    .undervoltage_det(uv), .second_strobe_function(strobe),
    .frame_sync_clock(frm), .double_rate_data_clock(dclk), .serial_bit_clock(bclk),
    .line_tx_clock(txc), .mclk_out(mclk), .reset_or_strobe_out(ros),
    .block_reset(blk), .oscillator_wake(owake));

  // 10 MHz clock.
  always #50 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int v);
    n_compared++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  // Holds the request until a rising edge samples waitrequest low; read data taken there.
  // Values read right at the edge are those that stood before it, as the slave sees them.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // Counts low samples of the reset output over n cycles.
  task automatic watch(input int n, output int lows);
    lows = 0;
    repeat (n) begin
      @(negedge clk);
      if (ros !== 1'b1) lows++;
    end
  endtask

  task automatic low_len(output int n);
    int w;
    n = 0;
    w = 0;
    while (ros !== 1'b0 && w < 7000) begin @(negedge clk); w++; end
    while (ros === 1'b0 && n < 20000) begin @(negedge clk); n++; end
  endtask

  task automatic mclk_half(output int n);
    int w;
    n = 0;
    w = 0;
    while (mclk !== 1'b0 && w < 100) begin @(negedge clk); w++; end
    while (mclk !== 1'b1 && w < 200) begin @(negedge clk); w++; end
    while (mclk === 1'b1 && n < 100) begin @(negedge clk); n++; end
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk("reset out in reset", 32'h0, {31'h0, ros});
    chk("blocks in reset", 32'hf, {28'h0, blk});
    @(posedge clk);
    reset_n <= 1'b1;
    low_len(len);
    rng("hw reset release", 1, 16, len);
    rdc("cfg default", `CRG_OFS_CFG, 32'h0);
    bus(1'b1, 5'h1c, 32'hffffffff);
    rdc("unmapped", 5'h1c, 32'h0);
    bus(1'b1, `CRG_OFS_SOFTRST, 32'h5);
    @(negedge clk);
    chk("soft reset held", 32'h5, {28'h0, blk});
    bus(1'b1, `CRG_OFS_SOFTRST, 32'h0);
    @(negedge clk);
    chk("soft reset free", 32'h0, {28'h0, blk});
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `CRG_OFS_CFG, mv[i]);
      mclk_half(h);
      mclk_half(h);
      chk("mclk half period", mh[i], h);
    end
    bus(1'b1, `CRG_OFS_CFG, 32'h3);
    repeat (5) @(negedge clk);
    bad = 0;
    repeat (40) begin @(negedge clk); if (mclk !== 1'b0) bad++; end
    chk("mclk off", 32'h0, bad);
    @(posedge clk);
    code <= 4'h3;
    watch(3000, bad);
    chk("no source selected", 32'h0, bad);
    // Frame, bit and data clocks over four frames.
    pf = frm;
    while (!(frm === 1'b1 && pf === 1'b0) && cyc < 20000) begin pf = frm; @(negedge clk); end
    fr = 0; nb = 0; nd = 0; bad = 0; rises = 0;
    pb = bclk; pd = dclk; pf = frm;
    while (rises < 4 && fr < 6000) begin
      @(negedge clk);
      fr++;
      if (bclk === 1'b1 && pb === 1'b0) nb++;
      if (dclk === 1'b1 && pd === 1'b0) nd++;
      if (frm === 1'b1 && pf === 1'b0) rises++;
      if (txc !== bclk) bad++;
      pb = bclk; pd = dclk; pf = frm;
    end
    rng("four frames", 4999, 5001, fr);
    rng("bit clocks", 383, 385, nb);
    rng("data clocks", 767, 769, nd);
    chk("tx clock", 32'h0, bad);
    // Strobe mode: the pin carries the strobe, and code changes do not show.
    bus(1'b1, `CRG_OFS_CFG, 32'h08);
    @(posedge clk);
    strobe <= 1'b1;
    repeat (3) @(negedge clk);
    chk("strobe high", 32'h1, {31'h0, ros});
    @(posedge clk);
    code <= 4'h5;
    watch(100, bad);
    chk("strobe mode code change", 32'h0, bad);
    @(posedge clk);
    strobe <= 1'b0;
    repeat (3) @(negedge clk);
    chk("strobe low", 32'h0, {31'h0, ros});
    // Command change and wake sources.
    bus(1'b1, `CRG_OFS_CFG, 32'h10);
    @(posedge clk);
    pulse_en <= 1'b1;
    code <= 4'ha;
    low_len(len);
    rng("code change pulse", 1250, 2500, len);
    @(posedge clk);
    wake_n <= 1'b0;
    @(negedge clk);
    chk("oscillator wake", 32'h1, {31'h0, owake});
    @(posedge clk);
    wake_n <= 1'b1;
    low_len(len);
    rng("wake pulse", 1250, 2500, len);
    // Watchdog serviced three times, then left to expire.
    @(posedge clk);
    pulse_en <= 1'b0;
    bus(1'b1, `CRG_OFS_CFG, 32'h18);
    len = 0;
    repeat (3) begin
      watch(3000, bad);
      len += bad;
      bus(1'b1, `CRG_OFS_WDT, 32'h1);
      bus(1'b1, `CRG_OFS_WDT, 32'h2);
    end
    chk("serviced watchdog", 32'h0, len);
    bus(1'b1, `CRG_OFS_WDT, 32'h1);
    bus(1'b0, `CRG_OFS_STAT, 32'h0);
    chk("tracker armed", 32'h1, {31'h0, rd[2]});
    bus(1'b1, `CRG_OFS_WDT, 32'h3);
    bus(1'b0, `CRG_OFS_STAT, 32'h0);
    chk("tracker disarmed", 32'h0, {31'h0, rd[2]});
    bus(1'b1, `CRG_OFS_WDT, 32'h2);
    low_len(len);
    rng("watchdog pulse", 1249, 1251, len);
    rdc("overflow flag", `CRG_OFS_ISR, 32'h1);
    bus(1'b1, `CRG_OFS_ISR, 32'h1);
    rdc("overflow cleared", `CRG_OFS_ISR, 32'h0);
    bus(1'b1, `CRG_OFS_CFG, 32'h0);
    rdc("select locked", `CRG_OFS_CFG, 32'h18);
    // Undervoltage detection enabled by the strap.
    @(posedge clk);
    reset_n <= 1'b0;
    strap <= 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    low_len(len);
    rng("deactivation hold", 49, 52, len);
    bus(1'b1, `CRG_OFS_CFG, 32'h2);
    mclk_half(h);
    while (mclk !== 1'b1 && cyc < 80000) @(negedge clk);
    @(posedge clk);
    uv <= 1'b1;
    @(negedge clk);
    chk("mclk stopped", 32'h0, {31'h0, mclk});
    // The output hold is a register, so it shows from the next edge on.
    @(negedge clk);
    chk("undervoltage reset", 32'h0, {31'h0, ros});
    repeat (20) @(posedge clk);
    uv <= 1'b0;
    low_len(len);
    rng("undervoltage hold", 49, 52, len);
    rdc("cfg after undervoltage", `CRG_OFS_CFG, 32'h0);
    mclk_half(h);
    mclk_half(h);
    chk("mclk default rate", 32'h2, h);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
